/* logic/tritmr_defines.svh */
// Register offsets, field positions and reset values of the triple timer
`ifndef TRITMR_DEFINES_SVH
`define TRITMR_DEFINES_SVH
`define TRITMR_NUM_TIMERS 3
`define TRITMR_CNT_W 24
`define TRITMR_CSR_STRIDE 32'h0000_0010
`define TRITMR_OFS_CSR 32'h0000_0000
`define TRITMR_OFS_LIMIT 32'h0000_0004
`define TRITMR_OFS_COUNT 32'h0000_0008
`define TRITMR_OFS_IRQ_STAT 32'h0000_0030
`define TRITMR_OFS_IRQ_MASK 32'h0000_0034
`define TRITMR_OFS_PWR 32'h0000_0038
`define TRITMR_CSR_EN_BIT 0
`define TRITMR_CSR_MODE_LSB 1
`define TRITMR_CSR_MODE_MSB 3
`define TRITMR_CSR_GPDIR_BIT 4
`define TRITMR_CSR_GPOUT_BIT 5
`define TRITMR_CSR_EXTSRC_BIT 6
`define TRITMR_CSR_PININ_BIT 8
`define TRITMR_CSR_PINOE_BIT 9
`define TRITMR_CSR_DONE_BIT 10
`define TRITMR_PWR_STOP_BIT 0
`define TRITMR_PWR_WAIT_BIT 1
`define TRITMR_LIMIT_RST 24'hFF_FFFF
`endif

/* logic/tritmr_pkg.sv */
// Types shared by the triple timer
package tritmr_pkg;
  typedef enum logic [2:0] {
    TRITMR_GPIO = 3'b000,
    TRITMR_TIMER = 3'b001,
    TRITMR_WATCHDOG = 3'b010,
    TRITMR_PWM = 3'b011,
    TRITMR_EVENT = 3'b100,
    TRITMR_MEASURE = 3'b101
  } tritmr_mode_t;

  typedef struct packed {
    logic enable;
    tritmr_mode_t mode;
    logic gpDir;
    logic gpOut;
    logic extSrc;
    logic [23:0] limit;
    logic [23:0] count;
    logic done;
    logic pinOut;
    logic pinOe;
    logic [2:0] pinSync;
    logic pinLevel;
  } tritmr_chan_t;

  typedef struct packed {
    tritmr_chan_t [2:0] chan;
    logic [2:0] irqStat;
    logic [2:0] irqMask;
    logic stopReq;
    logic waitReq;
    logic [31:0] prdata;
  } tritmr_state_t;
endpackage

/* logic/tritmr_top.sv */
// Three independent timer/counters with pin control behind an APB slave
`timescale 1ns/100ps
`default_nettype none
`include "tritmr_defines.svh"

// Summary of operation
// [R1] Three identical timers run independently, each with its own pin and control/status word.
// [R2] Each timer counts either system clocks or synchronised rising edges on its own pin.
// [R3] A timer that reaches its limit sets a sticky interrupt bit that drives the interrupt line.
// [R4] At the limit the pin toggles in timer mode and is set high in watchdog mode; in pulse mode it is high while the count is below half the limit.
// [R5] Event counter and measurement modes leave the pin as an input.
// [R6] Watchdog, timer and pulse-modulation modes drive the pin from the timer.
// [R7] After reset each pin is an undriven general-purpose input and is ignored during reset.
// [R8] Software control bits select general-purpose output or hand the pin to the timer.
// [R9] In Stop a pin last used as input is ignored.
// [R10] In Stop a pin last used as output keeps its level through a keeper with driver off.
// [R11] Each timer holds a loadable limit and flags the count reaching it.
// [R12] The Wait state leaves pin configuration and level unchanged.
module tritmr_top #(
  parameter int NUM_TIMERS = `TRITMR_NUM_TIMERS,
  parameter int CNT_W = `TRITMR_CNT_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer pins
  input wire logic [2:0] timerPinIn,
  output logic [2:0] timerPinOut,
  output logic [2:0] timerPinOe,
  output logic [2:0] timerPinKeep,
  // Interrupt
  output logic timerIrq
);
  import tritmr_pkg::*;

  tritmr_state_t state_r;
  tritmr_state_t state_nxt;
  logic apbAccess;
  logic apbWrite;
  logic apbRead;
  logic [7:0] offs;
  logic [1:0] chIdx;
  logic addrOk;

  assign apbAccess = psel && penable;
  assign apbWrite = apbAccess && pwrite;
  assign apbRead = apbAccess && !pwrite;
  assign chIdx = paddr[5:4];
  assign offs = {4'h0, paddr[3:0]};
  assign pready = 1'b1;

  always_comb begin
    addrOk = 1'b0;
    if (paddr[1:0] == 2'b00) begin
      if (chIdx < 2'(NUM_TIMERS) && offs <= 8'(`TRITMR_OFS_COUNT)) begin
        addrOk = 1'b1;
      end
      if (paddr == 8'(`TRITMR_OFS_IRQ_STAT) || paddr == 8'(`TRITMR_OFS_IRQ_MASK)
          || paddr == 8'(`TRITMR_OFS_PWR)) begin
        addrOk = 1'b1;
      end
    end
  end

  assign pslverr = apbAccess && !addrOk;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic [2:0] hit;
    logic edgeSeen;
    logic tick;
    logic timerOwnsPin;
    logic outMode;
    logic [31:0] csrWord;
    state_nxt = state_r;
    hit = 3'b000;
    edgeSeen = 1'b0;
    tick = 1'b0;
    timerOwnsPin = 1'b0;
    outMode = 1'b0;
    csrWord = 32'h0000_0000;

    // Stop and Wait requests from the power controller register
    if (apbWrite && addrOk && paddr == 8'(`TRITMR_OFS_PWR)) begin
      state_nxt.stopReq = pwdata[`TRITMR_PWR_STOP_BIT];
      state_nxt.waitReq = pwdata[`TRITMR_PWR_WAIT_BIT];
    end

    for (int i = 0; i < NUM_TIMERS; i++) begin // [R1]
      // Pin sampling, ignored while stopped with an input pin
      if (!(state_r.stopReq && !state_r.chan[i].pinOe)) begin // [R9]
        state_nxt.chan[i].pinSync = {state_r.chan[i].pinSync[1:0], timerPinIn[i]};
        if (state_r.chan[i].pinSync[2] == state_r.chan[i].pinSync[1]) begin
          state_nxt.chan[i].pinLevel = state_r.chan[i].pinSync[2];
        end
      end
      edgeSeen = state_nxt.chan[i].pinLevel && !state_r.chan[i].pinLevel;
      tick = state_r.chan[i].extSrc ? edgeSeen : 1'b1; // [R2]
      outMode = state_r.chan[i].mode == TRITMR_TIMER || state_r.chan[i].mode == TRITMR_WATCHDOG
                || state_r.chan[i].mode == TRITMR_PWM;
      timerOwnsPin = state_r.chan[i].enable && outMode;

      // Counting, frozen in Stop
      if (state_r.chan[i].enable && state_r.chan[i].mode != TRITMR_GPIO && !state_r.stopReq
          && tick) begin
        if (state_r.chan[i].count == state_r.chan[i].limit) begin // [R11]
          hit[i] = 1'b1;
          state_nxt.chan[i].done = 1'b1;
          state_nxt.chan[i].count = '0;
        end else begin
          state_nxt.chan[i].count = state_r.chan[i].count + 24'h00_0001;
        end
        if (state_r.chan[i].mode == TRITMR_PWM) begin
          state_nxt.chan[i].pinOut = state_r.chan[i].count < (state_r.chan[i].limit >> 1);
        end
      end

      // Pin drive per mode
      if (state_r.stopReq) begin
        state_nxt.chan[i].pinOe = state_r.chan[i].pinOe; // [R10]
      end else if (timerOwnsPin) begin
        state_nxt.chan[i].pinOe = 1'b1; // [R6]
        if (hit[i] && state_r.chan[i].mode == TRITMR_TIMER) begin
          state_nxt.chan[i].pinOut = !state_r.chan[i].pinOut; // [R4]
        end
        if (hit[i] && state_r.chan[i].mode == TRITMR_WATCHDOG) begin
          state_nxt.chan[i].pinOut = 1'b1; // [R4]
        end
      end else if (state_r.chan[i].mode == TRITMR_EVENT
                   || state_r.chan[i].mode == TRITMR_MEASURE) begin
        state_nxt.chan[i].pinOe = 1'b0; // [R5]
      end else begin
        state_nxt.chan[i].pinOe = state_r.chan[i].gpDir; // [R8]
        state_nxt.chan[i].pinOut = state_r.chan[i].gpOut; // [R8]
      end

      // Register writes
      if (apbWrite && addrOk && chIdx == 2'(i)) begin
        if (offs == 8'(`TRITMR_OFS_CSR)) begin
          state_nxt.chan[i].enable = pwdata[`TRITMR_CSR_EN_BIT];
          state_nxt.chan[i].mode =
            tritmr_mode_t'(pwdata[`TRITMR_CSR_MODE_MSB:`TRITMR_CSR_MODE_LSB]); // [R8]
          state_nxt.chan[i].gpDir = pwdata[`TRITMR_CSR_GPDIR_BIT];
          state_nxt.chan[i].gpOut = pwdata[`TRITMR_CSR_GPOUT_BIT];
          state_nxt.chan[i].extSrc = pwdata[`TRITMR_CSR_EXTSRC_BIT];
          if (!pwdata[`TRITMR_CSR_EN_BIT]) begin
            state_nxt.chan[i].count = '0;
          end
          if (pwdata[`TRITMR_CSR_DONE_BIT] && !hit[i]) begin
            state_nxt.chan[i].done = 1'b0;
          end
        end
        if (offs == 8'(`TRITMR_OFS_LIMIT)) begin
          state_nxt.chan[i].limit = pwdata[23:0]; // [R11]
        end
        if (offs == 8'(`TRITMR_OFS_COUNT)) begin
          state_nxt.chan[i].count = pwdata[23:0];
        end
      end
    end

    // Interrupt status: read clears, a new hit wins
    if (apbRead && paddr == 8'(`TRITMR_OFS_IRQ_STAT)) begin
      state_nxt.irqStat = hit; // [R3]
    end else begin
      state_nxt.irqStat = state_r.irqStat | hit; // [R3]
    end
    if (apbWrite && paddr == 8'(`TRITMR_OFS_IRQ_MASK)) begin
      state_nxt.irqMask = pwdata[2:0];
    end

    // Read data capture during the access phase
    state_nxt.prdata = 32'h0000_0000;
    if (apbRead && addrOk) begin
      if (paddr == 8'(`TRITMR_OFS_IRQ_STAT)) begin
        state_nxt.prdata = {29'h0, state_r.irqStat};
      end else if (paddr == 8'(`TRITMR_OFS_IRQ_MASK)) begin
        state_nxt.prdata = {29'h0, state_r.irqMask};
      end else if (paddr == 8'(`TRITMR_OFS_PWR)) begin
        state_nxt.prdata = {30'h0, state_r.waitReq, state_r.stopReq};
      end else begin
        for (int i = 0; i < NUM_TIMERS; i++) begin
          if (chIdx == 2'(i)) begin
            csrWord = 32'h0000_0000;
            csrWord[`TRITMR_CSR_EN_BIT] = state_r.chan[i].enable;
            csrWord[`TRITMR_CSR_MODE_MSB:`TRITMR_CSR_MODE_LSB] = state_r.chan[i].mode;
            csrWord[`TRITMR_CSR_GPDIR_BIT] = state_r.chan[i].gpDir;
            csrWord[`TRITMR_CSR_GPOUT_BIT] = state_r.chan[i].gpOut;
            csrWord[`TRITMR_CSR_EXTSRC_BIT] = state_r.chan[i].extSrc;
            csrWord[`TRITMR_CSR_PININ_BIT] = state_r.chan[i].pinLevel;
            csrWord[`TRITMR_CSR_PINOE_BIT] = state_r.chan[i].pinOe;
            csrWord[`TRITMR_CSR_DONE_BIT] = state_r.chan[i].done;
            if (offs == 8'(`TRITMR_OFS_CSR)) begin
              state_nxt.prdata = csrWord;
            end else if (offs == 8'(`TRITMR_OFS_LIMIT)) begin
              state_nxt.prdata = {8'h00, state_r.chan[i].limit};
            end else begin
              state_nxt.prdata = {8'h00, state_r.chan[i].count};
            end
          end
        end
      end
    end
    if (state_r.waitReq) begin
      state_nxt.waitReq = state_nxt.waitReq; // [R12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= '0; // [R7]
      for (int i = 0; i < `TRITMR_NUM_TIMERS; i++) begin
        state_r.chan[i].limit <= `TRITMR_LIMIT_RST;
      end
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign prdata = state_r.prdata;
  assign timerIrq = |(state_r.irqStat & state_r.irqMask);

  for (genvar g = 0; g < 3; g++) begin : gPin
    assign timerPinOut[g] = state_r.chan[g].pinOut;
    assign timerPinOe[g] = state_r.chan[g].pinOe && !state_r.stopReq; // [R10]
    assign timerPinKeep[g] = state_r.chan[g].pinOe && state_r.stopReq; // [R10]
  end
endmodule
`default_nettype wire

/* tb/tritmr_top_sva.sv */
// Port checker for the triple timer
`timescale 1ns/100ps
`default_nettype none
module tritmr_chk #(
  parameter int NUM_TIMERS = 3,
  parameter int CNT_W = 24
) (
  // Clock, reset and APB
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and interrupt
  input wire logic [2:0] timerPinIn,
  input wire logic [2:0] timerPinOut,
  input wire logic [2:0] timerPinOe,
  input wire logic [2:0] timerPinKeep,
  input wire logic timerIrq
);
  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_rdy; acc |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  property p_rst; !$past(rst_b) |-> timerPinOe == 3'h0; endproperty
  a_rst: assert property (p_rst) else $error("pin driven at reset");
  property p_err; pslverr |-> acc; endproperty
  a_err: assert property (p_err) else $error("pslverr outside access");
  property p_rdz; !$past(acc && !pwrite) |-> prdata == 32'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("prdata not idle");
  property p_bad; acc && !pwrite && pslverr |=> prdata == 32'h0; endproperty
  a_bad: assert property (p_bad) else $error("unmapped read data");
  property p_keep; (timerPinKeep & timerPinOe) == 3'h0; endproperty
  a_keep: assert property (p_keep) else $error("keeper with driver on");
  property p_hold;
    (timerPinKeep & $past(timerPinKeep) & (timerPinOut ^ $past(timerPinOut))) == 3'h0;
  endproperty
  a_hold: assert property (p_hold) else $error("kept level moved");
  property p_oe; timerPinOe != $past(timerPinOe) |-> $past(wr) || $past(wr, 2); endproperty
  a_oe: assert property (p_oe) else $error("pin direction moved");
  property p_irq; $fell(timerIrq) |-> $past(acc) || $past(acc, 2); endproperty
  a_irq: assert property (p_irq) else $error("interrupt dropped");
endmodule
`default_nettype wire

/* tb/tritmr_pin_model.sv */
// Outside device on the three timer pins
`timescale 1ns/100ps
`default_nettype none
module tritmr_pin_model (
  // Clock
  input wire logic clk_sys,
  // Device side
  input wire logic [2:0] pinOut,
  input wire logic [2:0] pinOe,
  input wire logic [2:0] pinKeep,
  // Wire level
  output logic [2:0] pinIn
);
  logic [2:0] srcLevel = 3'h0;
  logic [2:0] held;
  assign held = pinOe | pinKeep;
  // Keeper holds the last level while the driver is off
  assign pinIn = (held & pinOut) | (~held & srcLevel);
  task automatic pulse(input int ch, input int n);
    repeat (n) begin
      @(posedge clk_sys) srcLevel[ch] <= 1'b1;
      repeat (6) @(posedge clk_sys);
      srcLevel[ch] <= 1'b0;
      repeat (6) @(posedge clk_sys);
    end
  endtask
endmodule
`default_nettype wire

/* tb/test_tritmr_top.sv */
// Self-checking bench for the triple timer
`timescale 1ns/100ps
`default_nettype none
module test_tritmr_top;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} tritmr_row_t;
  logic clk_sys = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, timerIrq, er;
  logic [2:0] pinIn, pinOut, pinOe, pinKeep;
  int n_errors = 0, tests_run = 0, cyc = 0;
  tritmr_row_t rows [6] = '{'{0, 8'h04, 0, 32'h00FFFFFF}, '{0, 8'h14, 0, 32'h00FFFFFF},
    '{0, 8'h24, 0, 32'h00FFFFFF}, '{0, 8'h34, 0, 0}, '{1, 8'h14, 5, 0}, '{0, 8'h14, 0, 5}};
  tritmr_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timerPinIn(pinIn), .timerPinOut(pinOut), .timerPinOe(pinOe),
    .timerPinKeep(pinKeep), .timerIrq(timerIrq));
  tritmr_pin_model pins (.clk_sys(clk_sys), .pinOut(pinOut), .pinOe(pinOe),
    .pinKeep(pinKeep), .pinIn(pinIn));
  initial forever #25 clk_sys = ~clk_sys;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Read data is registered at the access edge
    #1 rd = prdata;
  endtask
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) check("reg", rd, rows[i].e);
    end
    apb(0, 8'h3C, 0);
    check("unmapped err", er, 1);
    check("unmapped data", rd, 0);
    $display("register test done");
    apb(1, 8'h04, 3);
    apb(1, 8'h34, 1);
    apb(1, 8'h00, 32'h3);
    settle();
    check("timer oe", pinOe[0], 1);
    for (int k = 0; k < 20 && timerIrq !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    check("timer irq", timerIrq, 1);
    settle();
    check("timer pin", pinOut[0], 1);
    apb(1, 8'h00, 0);
    apb(0, 8'h30, 0);
    check("status", rd[0], 1);
    apb(0, 8'h30, 0);
    check("cleared irq", timerIrq, 0);
    check("cleared data", rd, 0);
    apb(0, 8'h00, 0);
    check("done flag", rd[10], 1);
    apb(1, 8'h00, 32'h5);
    repeat (8) @(posedge clk_sys);
    #1;
    check("watchdog pin", {pinOe[0], pinOut[0]}, 3);
    apb(1, 8'h00, 0);
    apb(0, 8'h30, 0);
    check("watchdog status", rd[0], 1);
    $display("timer test done");
    apb(1, 8'h10, 32'h49);
    settle();
    check("event oe", pinOe[1], 0);
    pins.pulse(1, 3);
    apb(0, 8'h18, 0);
    check("event count", rd, 3);
    $display("event test done");
    apb(1, 8'h20, 32'h30);
    settle();
    check("gp out", {pinOe[2], pinOut[2]}, 3);
    apb(1, 8'h38, 2);
    settle();
    check("wait", {pinOe[2], pinOut[2]}, 3);
    apb(1, 8'h38, 1);
    settle();
    check("stop keep", {pinKeep, pinOe[2], pinIn[2]}, 5'b10001);
    pins.pulse(1, 2);
    apb(0, 8'h18, 0);
    check("stop count", rd, 3);
    apb(1, 8'h38, 0);
    $display("power test done");
    @(posedge clk_sys) rst_b <= 1'b0;
    settle();
    check("reset oe", pinOe, 0);
    @(posedge clk_sys) rst_b <= 1'b1;
    settle();
    check("after reset", {pinOe, pinKeep}, 0);
    $display("reset test done");
    stop_test();
  end
endmodule
bind tritmr_top tritmr_chk #(.NUM_TIMERS(NUM_TIMERS), .CNT_W(CNT_W)) chk (.*);
`default_nettype wire
